// [hw/ccs_alu.sv]
// result, destination and skip logic for one decoded instruction
`timescale 1ns/100ps
module ccs_alu
(
   // decoded instruction and operand
   input  wire ccs_pkg::ccs_dec_t dec,
   input  wire logic [7:0]        file_val,
   // result
   output ccs_pkg::ccs_res_t      res
);

   always_comb
   begin
      res = '0;
      unique case (dec.op)
         ccs_pkg::OP_CALL:
            res.two_cycle = 1'b1;
         ccs_pkg::OP_COMPLEMENT_REG_OP:
         begin
            res.value = ~file_val;
            res.set_z = 1'b1;
         end
         ccs_pkg::OP_CLEAR_REG_OP:
         begin
            res.value   = 8'h00;
            res.wr_file = 1'b1;
            res.set_z   = 1'b1;
         end
         ccs_pkg::OP_DECREMENT_REG_OP:
         begin
            res.value = file_val - 8'h01;
            res.set_z = 1'b1;
         end
         ccs_pkg::OP_CLEAR_ACCUMULATOR_OP:
         begin
            res.value  = 8'h00;
            res.wr_acc = 1'b1;
            res.set_z  = 1'b1;
         end
         ccs_pkg::OP_DECREMENT_SKIP_ZERO_OP:
            res.value = file_val - 8'h01;
         ccs_pkg::OP_INCREMENT_SKIP_ZERO_OP:
            res.value = file_val + 8'h01;
         default:
            res.value = 8'h00;
      endcase
      res.zero = (res.value == 8'h00);
      if (dec.op == ccs_pkg::OP_COMPLEMENT_REG_OP || dec.op == ccs_pkg::OP_DECREMENT_REG_OP ||
          dec.op == ccs_pkg::OP_DECREMENT_SKIP_ZERO_OP || dec.op == ccs_pkg::OP_INCREMENT_SKIP_ZERO_OP)
      begin
         res.wr_file = dec.dest;
         res.wr_acc  = ~dec.dest;
      end
      if (dec.op == ccs_pkg::OP_DECREMENT_SKIP_ZERO_OP || dec.op == ccs_pkg::OP_INCREMENT_SKIP_ZERO_OP)
      begin
         res.skip      = res.zero;
         res.two_cycle = res.zero;
      end
   end

endmodule

// [hw/ccs_exec_top.sv]
// execution block with accumulator, file registers, stack and bus slave
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module ccs_exec_top
#(
   parameter int unsigned FILE_DEPTH  = 128,
   parameter int unsigned STACK_DEPTH = 8
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // write address channel
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // write data channel
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // write response channel
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // read address channel
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // read data channel
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   localparam int unsigned SP_W = $clog2(STACK_DEPTH);

   // ****************************************
   // state
   // ****************************************
   ccs_pkg::ccs_state_t state_q;
   ccs_pkg::ccs_dec_t   dec_q;
   ccs_pkg::ccs_res_t   res;
   logic [7:0]          acc_q;
   logic [12:0]         pc_q;
   logic [7:0]          program_counter_high_latch_q;
   logic [12:0]         stack_q [STACK_DEPTH];
   logic [SP_W-1:0]     sp_q;
   logic [7:0]          file_q [FILE_DEPTH];
   logic [6:0]          fsel_q;
   logic                z_q;
   logic                bad_q;
   logic                awready_q;
   logic                aw_have_q;
   logic [7:0]          awaddr_q;
   logic                wready_q;
   logic                w_have_q;
   logic [31:0]         wdata_q;
   logic [3:0]          wstrb_q;
   logic                bvalid_q;
   logic [1:0]          bresp_q;
   logic                arready_q;
   logic                rvalid_q;
   logic [31:0]         rdata_q;
   logic [1:0]          rresp_q;

   logic                busy;
   logic                exec_en;
   logic                sec_en;
   logic                do_wr;
   logic                wr_ok;
   logic [7:0]          wa;
   logic [7:0]          ra;
   logic [31:0]         rd_word;
   logic                rd_hit;
   logic                wr_hit;
   logic [7:0]          fval;
   logic [12:0]         return_stack_top;
   logic [12:0]         pc_next;

   // ****************************************
   // byte-lane merge of a write
   // ****************************************
   function automatic logic [31:0] ccs_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            m[b*8 +: 8] = nw[b*8 +: 8];
      end
      return m;
   endfunction

   assign busy             = (state_q != ccs_pkg::ST_IDLE);
   assign exec_en          = (state_q == ccs_pkg::ST_EXEC);
   assign sec_en           = (state_q == ccs_pkg::ST_SECOND);
   assign fval             = file_q[dec_q.faddr];
   assign return_stack_top = stack_q[sp_q - SP_W'(1)];
   assign pc_next          = pc_q + 13'h0001;
   assign wa               = {awaddr_q[7:2], 2'h0};
   assign ra               = {s_axi_araddr[7:2], 2'h0};
   assign do_wr            = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_hit           = (wa == ccs_pkg::OFF_INSTR) ||
                             (wa == ccs_pkg::OFF_STATUS) ||
                             (wa == ccs_pkg::OFF_ACC) ||
                             (wa == ccs_pkg::OFF_PC) ||
                             (wa == ccs_pkg::OFF_LATCH) ||
                             (wa == ccs_pkg::OFF_FSEL) ||
                             (wa == ccs_pkg::OFF_FDATA);
   assign wr_ok            = do_wr & wr_hit & ~busy;

   ccs_alu u_alu
   (
      .dec      (dec_q),
      .file_val (fval),
      .res      (res)
   );

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ccs_pkg::ST_IDLE;
         dec_q   <= '0;
      end
      else
      begin
         unique case (state_q)
            ccs_pkg::ST_IDLE:
               if (wr_ok && wa == ccs_pkg::OFF_INSTR)
               begin
                  dec_q   <= ccs_pkg::ccs_decode(wdata_q[13:0]);
                  state_q <= ccs_pkg::ST_EXEC;
               end
            ccs_pkg::ST_EXEC:
               state_q <= res.two_cycle ? ccs_pkg::ST_SECOND
                                        : ccs_pkg::ST_IDLE;
            ccs_pkg::ST_SECOND:
               state_q <= ccs_pkg::ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // program counter and return stack
   // ****************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pc_q <= ccs_pkg::PC_RST;
      else if (exec_en && dec_q.op != ccs_pkg::OP_CALL)
         pc_q <= pc_next;
      else if (sec_en && dec_q.op == ccs_pkg::OP_CALL)
         pc_q <= {program_counter_high_latch_q[4:3], dec_q.target};
      else if (sec_en)
         pc_q <= pc_next;
      else if (wr_ok && wa == ccs_pkg::OFF_PC)
         pc_q <= 13'(ccs_merge({19'h00000, pc_q}, wdata_q, wstrb_q));
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sp_q <= '0;
         for (int i = 0; i < STACK_DEPTH; i++)
            stack_q[i] <= ccs_pkg::PC_RST;
      end
      else if (exec_en && dec_q.op == ccs_pkg::OP_CALL)
      begin
         stack_q[sp_q] <= pc_next;
         sp_q          <= sp_q + SP_W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         program_counter_high_latch_q <= ccs_pkg::LATCH_RST;
      else if (wr_ok && wa == ccs_pkg::OFF_LATCH)
         program_counter_high_latch_q <=
            8'(ccs_merge({24'h000000, program_counter_high_latch_q},
                         wdata_q, wstrb_q));
   end

   // ****************************************
   // accumulator, file registers, flags
   // ****************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         acc_q <= ccs_pkg::ACC_RST;
      else if (exec_en && res.wr_acc)
         acc_q <= res.value;
      else if (wr_ok && wa == ccs_pkg::OFF_ACC)
         acc_q <= 8'(ccs_merge({24'h000000, acc_q}, wdata_q, wstrb_q));
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < FILE_DEPTH; i++)
            file_q[i] <= ccs_pkg::FILE_RST;
      end
      else if (exec_en && res.wr_file)
         file_q[dec_q.faddr] <= res.value;
      else if (wr_ok && wa == ccs_pkg::OFF_FDATA)
         file_q[fsel_q] <= 8'(ccs_merge({24'h000000, file_q[fsel_q]},
                                        wdata_q, wstrb_q));
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         fsel_q <= 7'h00;
      else if (wr_ok && wa == ccs_pkg::OFF_FSEL && wstrb_q[0])
         fsel_q <= wdata_q[6:0];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         z_q <= 1'b0;
      else if (exec_en && res.set_z)
         z_q <= res.zero;
      else if (wr_ok && wa == ccs_pkg::OFF_STATUS && wstrb_q[0])
         z_q <= wdata_q[ccs_pkg::ST_Z_BIT];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         bad_q <= 1'b0;
      else if (exec_en && dec_q.op == ccs_pkg::OP_BAD)
         bad_q <= 1'b1;
      else if (wr_ok && wa == ccs_pkg::OFF_STATUS && wstrb_q[0] &&
               wdata_q[ccs_pkg::ST_BAD])
         bad_q <= 1'b0;
   end

   // ****************************************
   // bus write path
   // ****************************************
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         awready_q <= 1'b1;
         aw_have_q <= 1'b0;
         awaddr_q  <= 8'h00;
      end
      else if (s_axi_awvalid && awready_q)
      begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end
      else if (bvalid_q && s_axi_bready)
      begin
         awready_q <= 1'b1;
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wready_q <= 1'b1;
         w_have_q <= 1'b0;
         wdata_q  <= 32'h00000000;
         wstrb_q  <= 4'h0;
      end
      else if (s_axi_wvalid && wready_q)
      begin
         wready_q <= 1'b0;
         w_have_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end
      else if (bvalid_q && s_axi_bready)
      begin
         wready_q <= 1'b1;
         w_have_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= ccs_pkg::RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_ok ? ccs_pkg::RESP_OKAY : ccs_pkg::RESP_SLV;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // ****************************************
   // bus read path
   // ****************************************
   always_comb
   begin
      rd_hit  = 1'b1;
      rd_word = 32'h00000000;
      unique case (ra)
         ccs_pkg::OFF_STATUS: rd_word = {29'h00000000, bad_q, busy, z_q};
         ccs_pkg::OFF_ACC:    rd_word = {24'h000000, acc_q};
         ccs_pkg::OFF_PC:     rd_word = {19'h00000, pc_q};
         ccs_pkg::OFF_LATCH:
            rd_word = {24'h000000, program_counter_high_latch_q};
         ccs_pkg::OFF_STACK:  rd_word = {19'h00000, return_stack_top};
         ccs_pkg::OFF_FSEL:   rd_word = {25'h0000000, fsel_q};
         ccs_pkg::OFF_FDATA:  rd_word = {24'h000000, file_q[fsel_q]};
         ccs_pkg::OFF_INSTR:  rd_word = 32'h00000000;
         default:             rd_hit  = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= ccs_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_word;
         rresp_q   <= rd_hit ? ccs_pkg::RESP_OKAY : ccs_pkg::RESP_SLV;
      end
      else if (rvalid_q && s_axi_rready)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // ****************************************
   // checks
   // ****************************************
   logic [7:0]  dest_val;
   logic [1:0]  latch_page;
   logic [10:0] call_target;
   logic        is_call;
   logic        is_skip_op;

   assign dest_val    = dec_q.dest ? fval : acc_q;
   assign latch_page  = program_counter_high_latch_q[4:3];
   assign call_target = dec_q.target;
   assign is_call     = exec_en && dec_q.op == ccs_pkg::OP_CALL;
   assign is_skip_op  = exec_en && (dec_q.op == ccs_pkg::OP_DECREMENT_SKIP_ZERO_OP ||
                                    dec_q.op == ccs_pkg::OP_INCREMENT_SKIP_ZERO_OP);

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_call;
      is_call ##1 sec_en;
   endsequence

   sequence s_skip;
      is_skip_op && res.skip ##1 sec_en;
   endsequence

   AST_CALL_PUSH: assert property (
      is_call |=> return_stack_top == $past(pc_q) + 13'h0001)
      else $error("call pushed wrong return address");
   AST_CALL_LOW: assert property (
      s_call |=> pc_q[10:0] == $past(call_target))
      else $error("call target not in pc low bits");
   AST_CALL_HI: assert property (
      s_call |=> pc_q[12:11] == $past(latch_page))
      else $error("call page bits not from latch");
   AST_CALL_TWO: assert property (
      is_call |=> sec_en && $stable(z_q) ##1 !busy && $stable(z_q))
      else $error("call not two cycles or flag moved");
   AST_COMPLEMENT_REG_OP: assert property (
      exec_en && dec_q.op == ccs_pkg::OP_COMPLEMENT_REG_OP |=>
         dest_val == ~$past(fval) && z_q == (dest_val == 8'h00))
      else $error("complement result or zero flag wrong");
   AST_CLEAR_REG_OP: assert property (
      exec_en && dec_q.op == ccs_pkg::OP_CLEAR_REG_OP |=> fval == 8'h00 && z_q)
      else $error("clear register failed");
   AST_DECREMENT_REG_OP: assert property (
      exec_en && dec_q.op == ccs_pkg::OP_DECREMENT_REG_OP |=>
         dest_val == $past(fval) - 8'h01 && z_q == (dest_val == 8'h00))
      else $error("decrement result or zero flag wrong");
   AST_CLEAR_ACCUMULATOR_OP: assert property (
      exec_en && dec_q.op == ccs_pkg::OP_CLEAR_ACCUMULATOR_OP |=> acc_q == 8'h00 && z_q)
      else $error("clear accumulator failed");
   AST_DSZ: assert property (
      exec_en && dec_q.op == ccs_pkg::OP_DECREMENT_SKIP_ZERO_OP |=>
         dest_val == $past(fval) - 8'h01 && $stable(z_q))
      else $error("decrement-skip result or flag wrong");
   AST_SKIP: assert property (
      is_skip_op && res.skip |-> ##2 pc_q == $past(pc_q, 2) + 13'h0002)
      else $error("zero result did not skip next");
   AST_NOSKIP: assert property (
      is_skip_op && !res.skip |=> !busy && pc_q == $past(pc_q) + 13'h0001)
      else $error("nonzero result skipped");
   AST_ISZ: assert property (
      exec_en && dec_q.op == ccs_pkg::OP_INCREMENT_SKIP_ZERO_OP |=>
         dest_val == $past(fval) + 8'h01 && $stable(z_q))
      else $error("increment-skip result or flag wrong");
   AST_SKIP_END: assert property (
      s_skip |=> !busy)
      else $error("skip cycle not closed");

endmodule

// [hw/ccs_pkg.sv]
// constants, types and decode for the call/clear/step/skip execution block
package ccs_pkg;

   // ****************************************
   // widths and field positions
   // ****************************************
   localparam int unsigned AXI_ADDR_W = 8;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned PC_W       = 13;
   localparam int unsigned INSTR_W    = 14;
   localparam int unsigned CLASS_HI   = 13;
   localparam int unsigned CLASS_LO   = 12;
   localparam int unsigned CODE_HI    = 11;
   localparam int unsigned CODE_LO    = 8;
   localparam int unsigned DEST_BIT   = 7;
   localparam int unsigned FADDR_HI   = 6;
   localparam int unsigned TARGET_HI  = 10;
   localparam int unsigned LATCH_HI   = 4;
   localparam int unsigned LATCH_LO   = 3;
   localparam int unsigned ST_Z_BIT   = 0;
   localparam int unsigned ST_BUSY    = 1;
   localparam int unsigned ST_BAD     = 2;

   // ****************************************
   // opcode field values
   // ****************************************
   localparam logic [1:0] CLASS_CALL = 2'h2;
   localparam logic [1:0] CLASS_FILE = 2'h0;
   localparam logic [3:0] CODE_NOP   = 4'h0;
   localparam logic [3:0] CODE_COMPLEMENT_REG_OP  = 4'h1;
   localparam logic [3:0] CODE_CLEAR_REG_OP  = 4'h2;
   localparam logic [3:0] CODE_DECREMENT_REG_OP  = 4'h3;
   localparam logic [3:0] CODE_CLEAR_ACCUMULATOR_OP  = 4'h4;
   localparam logic [3:0] CODE_DSZ   = 4'h5;
   localparam logic [3:0] CODE_ISZ   = 4'h6;

   // ****************************************
   // register offsets and reset values
   // ****************************************
   localparam logic [7:0] OFF_INSTR  = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_ACC    = 8'h08;
   localparam logic [7:0] OFF_PC     = 8'h0C;
   localparam logic [7:0] OFF_LATCH  = 8'h10;
   localparam logic [7:0] OFF_STACK  = 8'h14;
   localparam logic [7:0] OFF_FSEL   = 8'h18;
   localparam logic [7:0] OFF_FDATA  = 8'h1C;
   localparam logic [7:0]  ACC_RST   = 8'h00;
   localparam logic [7:0]  FILE_RST  = 8'h00;
   localparam logic [7:0]  LATCH_RST = 8'h00;
   localparam logic [12:0] PC_RST    = 13'h0000;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   localparam logic [1:0]  RESP_SLV  = 2'h2;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [3:0] {
      OP_NOP, OP_CALL, OP_COMPLEMENT_REG_OP, OP_CLEAR_REG_OP, OP_DECREMENT_REG_OP,
      OP_CLEAR_ACCUMULATOR_OP, OP_DECREMENT_SKIP_ZERO_OP, OP_INCREMENT_SKIP_ZERO_OP, OP_BAD
   } ccs_op_t;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} ccs_state_t;

   typedef struct packed {
      ccs_op_t     op;
      logic        dest;
      logic [6:0]  faddr;
      logic [10:0] target;
   } ccs_dec_t;

   typedef struct packed {
      logic [7:0] value;
      logic       zero;
      logic       wr_file;
      logic       wr_acc;
      logic       set_z;
      logic       skip;
      logic       two_cycle;
   } ccs_res_t;

   // ****************************************
   // instruction word decode
   // ****************************************
   function automatic ccs_dec_t ccs_decode(input logic [13:0] w);
      ccs_dec_t d;
      d.dest   = w[DEST_BIT];
      d.faddr  = w[FADDR_HI:0];
      d.target = w[TARGET_HI:0];
      d.op     = OP_BAD;
      if (w[CLASS_HI:CLASS_LO] == CLASS_CALL)
         d.op = OP_CALL;
      else if (w[CLASS_HI:CLASS_LO] == CLASS_FILE)
      begin
         unique case (w[CODE_HI:CODE_LO])
            CODE_NOP:  d.op = OP_NOP;
            CODE_COMPLEMENT_REG_OP: d.op = OP_COMPLEMENT_REG_OP;
            CODE_CLEAR_REG_OP: d.op = OP_CLEAR_REG_OP;
            CODE_DECREMENT_REG_OP: d.op = OP_DECREMENT_REG_OP;
            CODE_CLEAR_ACCUMULATOR_OP: d.op = OP_CLEAR_ACCUMULATOR_OP;
            CODE_DSZ:  d.op = OP_DECREMENT_SKIP_ZERO_OP;
            CODE_ISZ:  d.op = OP_INCREMENT_SKIP_ZERO_OP;
            default:   d.op = OP_BAD;
         endcase
      end
      return d;
   endfunction

endpackage

// [verification/tb_call_clear_step_skip_exec.sv]
// self-checking bench for the execution block over its register bus
`timescale 1ns/100ps
module tb_call_clear_step_skip_exec;
   logic        clk, rst;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, v;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata;
   int          errors, n_tests;

   ccs_exec_top i_ccs_exec_top
   (
      .clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ****************************************
   // bus tasks and checks
   // ****************************************
   task stop_test;
      $display("compares %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            chk({30'h0, bresp}, {30'h0, er});
            bready <= 1'b0;
            break;
         end
      end
      if (i == 50)
      begin
         errors++;
         stop_test;
      end
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
      int i;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            d = rdata; e = rresp; rready <= 1'b0;
            break;
         end
      end
      if (i == 50)
      begin
         errors++;
         stop_test;
      end
   endtask

   task rc(input logic [7:0] a, input logic [31:0] e);
      rd(a, v, r);
      chk(v, e);
   endtask

   task ex(input logic [13:0] w);
      int j;
      wr(8'h00, {18'h0, w}, 2'h0);
      for (j = 0; j < 20; j++)
      begin
         rd(8'h04, v, r);
         if (v[1] === 1'b0) break;
      end
      if (j == 20)
      begin
         errors++;
         stop_test;
      end
   endtask

   // one file-register operation on index 127, pc starting at 0x010
   task tf(input logic [3:0] c, input logic dd, input logic [7:0] ini,
           input logic zi, input logic [7:0] ef, input logic [7:0] ea,
           input logic ze, input logic [12:0] st);
      wr(8'h18, 32'h7F, 2'h0);
      wr(8'h1C, {24'h0, ini}, 2'h0);
      wr(8'h08, 32'h33, 2'h0);
      wr(8'h04, {31'h0, zi}, 2'h0);
      wr(8'h0C, 32'h10, 2'h0);
      ex({2'h0, c, dd, 7'h7F});
      rc(8'h1C, {24'h0, ef});
      rc(8'h08, {24'h0, ea});
      rd(8'h04, v, r);
      chk({31'h0, v[0]}, {31'h0, ze});
      rc(8'h0C, {19'h0, 13'h0010 + st});
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      errors = 0; n_tests = 0; rst = 1'b1;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rc(8'h08, 32'h0);
      rc(8'h0C, 32'h0);
      tf(4'h1, 1'b1, 8'h5A, 1'b1, 8'hA5, 8'h33, 1'b0, 13'h1);
      tf(4'h1, 1'b0, 8'hFF, 1'b0, 8'hFF, 8'h00, 1'b1, 13'h1);
      tf(4'h2, 1'b1, 8'h77, 1'b0, 8'h00, 8'h33, 1'b1, 13'h1);
      tf(4'h3, 1'b0, 8'h01, 1'b0, 8'h01, 8'h00, 1'b1, 13'h1);
      tf(4'h3, 1'b1, 8'h00, 1'b1, 8'hFF, 8'h33, 1'b0, 13'h1);
      tf(4'h4, 1'b0, 8'h44, 1'b0, 8'h44, 8'h00, 1'b1, 13'h1);
      $display("test clear and complement done");
      tf(4'h5, 1'b1, 8'h01, 1'b0, 8'h00, 8'h33, 1'b0, 13'h2);
      tf(4'h5, 1'b0, 8'h03, 1'b1, 8'h03, 8'h02, 1'b1, 13'h1);
      tf(4'h5, 1'b1, 8'h00, 1'b0, 8'hFF, 8'h33, 1'b0, 13'h1);
      tf(4'h6, 1'b0, 8'hFF, 1'b1, 8'hFF, 8'h00, 1'b1, 13'h2);
      tf(4'h6, 1'b1, 8'h7F, 1'b0, 8'h80, 8'h33, 1'b0, 13'h1);
      $display("test step and skip done");
      wr(8'h10, 32'h18, 2'h0);
      wr(8'h0C, 32'h123, 2'h0);
      wr(8'h04, 32'h1, 2'h0);
      ex(14'h27FF);
      rc(8'h14, 32'h124);
      rc(8'h0C, 32'h1FFF);
      rc(8'h04, 32'h1);
      wr(8'h10, 32'h08, 2'h0);
      wr(8'h04, 32'h0, 2'h0);
      ex(14'h2000);
      rc(8'h14, 32'h0);
      rc(8'h0C, 32'h0800);
      rc(8'h04, 32'h0);
      $display("test call done");
      wr(8'h40, 32'h1, 2'h2);
      wr(8'h14, 32'h1, 2'h2);
      rd(8'h40, v, r);
      chk({30'h0, r}, 32'h2);
      $display("test refused access done");
      stop_test;
   end
endmodule
